/* verilog/cas_sequencer.sv */
// Operand address sequencer with reset, interrupt, trap and wait sequences.
// Assumes a combinational memory: bus_rdata is valid in the cycle bus_rd is high.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - One 64 KB address space reaches memory, registers and ports alike.
// - Register-only mode fetches no operand from memory.
// - Branch offset byte follows opcode; taken branch adds sign-extended offset.
// - Literal operand follows opcode, high byte first when 16 bits.
// - Direct address gets an implied zero high byte.
// - Full address comes from two code bytes, high byte first.
// - Pointer no-offset mode uses the pointer pair as address.
// - Post-increment mode adds one to the pair after the fetch.
// - Byte offset mode adds unsigned byte; its post-increment form bumps pair.
// - Word offset mode adds a 16-bit offset to the pair.
// - Stack byte offset mode adds unsigned byte to stack pointer.
// - Stack word offset mode adds 16-bit offset to stack pointer.
// - Test-and-branch instructions fetch a further relative byte for the target.
// - Any reset abandons activity at once.
// - After reset, six cycles read the top vector and fill the queue.
// - Interrupts wait for the boundary; vector latched at sequence start.
// - Stack return low, return high, pointer low, accumulator, flags in order.
// - Then set mask, read vector high, low, one idle cycle, three prefetches.
// - Upper pointer byte is never stacked.
// - Software trap uses same sequence and ignores the mask.
// - Wait clears the mask and stops clocks until interrupt or reset.
// - Background command in wait restarts clocks into background mode.
// - Mask is flag bit 3; set blocks maskable interrupts.
module cas_sequencer (
    input  wire logic               sys_clk,
    input  wire logic               arst_n,
    input  wire logic               reset_done,
    input  wire logic               op_start,
    input  wire cas_pkg::cas_mode_t op_mode,
    input  wire logic               op_wide,
    input  wire logic               op_rel_tail,
    input  wire logic               br_decide,
    input  wire logic               br_taken,
    input  wire logic               irq_pending,
    input  wire logic [15:0]        int_vector,
    input  wire logic               swi_req,
    input  wire logic               wait_req,
    input  wire logic               bdm_background,
    input  wire logic               bdm_go,
    input  wire logic               hx_load,
    input  wire logic [15:0]        hx_in,
    input  wire logic               sp_load,
    input  wire logic [15:0]        sp_in,
    input  wire logic               imask_load,
    input  wire logic               imask_in,
    input  wire logic [7:0]         acc_in,
    input  wire logic [7:0]         ccr_in,
    input  wire logic [7:0]         bus_rdata,
    output logic [15:0]             bus_addr,
    output logic                    bus_rd,
    output logic                    bus_wr,
    output logic [7:0]              bus_wdata,
    output logic [15:0]             ea_addr,
    output logic                    ea_valid,
    output logic [15:0]             op_data,
    output logic [15:0]             pc,
    output logic [15:0]             hx,
    output logic [15:0]             sp,
    output logic                    i_mask,
    output logic                    cpu_clk_en,
    output logic                    bdm_active,
    output logic                    seq_idle,
    output logic                    branch_wait
);
    typedef enum logic [3:0] {
        ST_RST, ST_VHI, ST_VLO, ST_FREE, ST_PREF, ST_IDLE, ST_OPF,
        ST_EA, ST_RELF, ST_BR, ST_PUSH, ST_WAIT, ST_BDM
    } cas_state_t;

    cas_state_t         state;
    cas_state_t         next_state;
    logic [2:0]         cnt;
    cas_pkg::cas_mode_t mode_q;
    logic [1:0]         need_q;
    logic               rel_q;
    logic [15:0]        vec_q;
    logic [7:0]         rel_off;
    logic [15:0]        opnd;
    logic [15:0]        opbase;
    logic [7:0]         push_byte;
    logic [2:0]         push_idx;
    logic [1:0]         need_now;
    logic               take_irq;
    logic               take_swi;
    logic               take_wait;
    logic               take_op;
    logic               wake_irq;
    logic               wake_bdm;
    logic               push_go;
    logic               last_opf;
    logic               postinc;

    cas_ea_if eif ();
    cas_ea_calc u_ea (
        .eif (eif.calc)
    );
    assign eif.mode = mode_q;
    assign eif.hx   = hx;
    assign eif.sp   = sp;
    assign eif.base = opbase;
    assign eif.pc   = pc;
    assign eif.opnd = opnd;

    // Idle state is the instruction boundary; interrupts outrank a new opcode
    assign take_irq  = (state == ST_IDLE) && irq_pending && !i_mask;
    assign take_swi  = (state == ST_IDLE) && !take_irq && swi_req;
    assign take_wait = (state == ST_IDLE) && !take_irq && !swi_req && wait_req;
    assign take_op   = (state == ST_IDLE) && !take_irq && !swi_req && !wait_req && op_start;
    assign wake_irq  = (state == ST_WAIT) && irq_pending && !i_mask;
    assign wake_bdm  = (state == ST_WAIT) && !wake_irq && bdm_background;
    assign push_go   = take_irq || take_swi || wake_irq;
    assign need_now  = cas_pkg::operand_bytes(op_mode, op_wide);
    assign last_opf  = (cnt == {1'b0, need_q - 2'h1});
    assign postinc   = (mode_q == cas_pkg::pointer_postinc_mode) ||
                       (mode_q == cas_pkg::pointer_byte_offset_postinc_mode);
    assign push_idx  = (state == ST_PUSH) ? cnt + 3'h1 : 3'h0;

    always_comb begin
        case (push_idx)
            3'h0:    push_byte = pc[7:0];
            3'h1:    push_byte = pc[15:8];
            3'h2:    push_byte = hx[7:0];
            3'h3:    push_byte = acc_in;
            default: begin
                push_byte = ccr_in;
                push_byte[cas_pkg::IMASK_BIT] = i_mask;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_RST:  if (reset_done) next_state = ST_VHI;
            ST_VHI:  next_state = ST_VLO;
            ST_VLO:  next_state = ST_FREE;
            ST_FREE: next_state = ST_PREF;
            ST_PREF: if (cnt == cas_pkg::PREF_LAST) next_state = ST_IDLE;
            ST_IDLE: begin
                if (push_go) next_state = ST_PUSH;
                else if (take_wait) next_state = ST_WAIT;
                else if (take_op) next_state = (need_now == 2'h0) ? ST_EA : ST_OPF;
            end
            ST_OPF:  if (last_opf) next_state = ST_EA;
            ST_EA: begin
                if (mode_q == cas_pkg::relative_mode) next_state = ST_BR;
                else if (rel_q) next_state = ST_RELF;
                else next_state = ST_IDLE;
            end
            ST_RELF: next_state = ST_BR;
            ST_BR:   if (br_decide) next_state = ST_IDLE;
            ST_PUSH: if (cnt == cas_pkg::PUSH_LAST) next_state = ST_VHI;
            ST_WAIT: begin
                if (wake_irq) next_state = ST_PUSH;
                else if (wake_bdm) next_state = ST_BDM;
            end
            ST_BDM:  if (bdm_go) next_state = ST_IDLE;
            default: next_state = ST_RST;
        endcase
    end

    // Asynchronous reset drops any sequence mid-way
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_RST;
            cnt   <= 3'h0;
        end else begin
            state <= next_state;
            cnt   <= (next_state != state) ? 3'h0 : cnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q  <= cas_pkg::register_only_mode;
            need_q  <= 2'h0;
            rel_q   <= 1'b0;
            vec_q   <= cas_pkg::VEC_RESET;
            rel_off <= 8'h00;
        end else begin
            if (take_op) begin
                mode_q <= op_mode;
                need_q <= need_now;
                rel_q  <= op_rel_tail;
            end
            if (push_go) vec_q <= int_vector;
            if (state == ST_EA) rel_off <= opnd[7:0];
            if (state == ST_RELF) rel_off <= bus_rdata;
        end
    end

    // Bus strobes follow the state being entered, so all of them are flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_addr  <= 16'h0000;
            bus_rd    <= 1'b0;
            bus_wr    <= 1'b0;
            bus_wdata <= 8'h00;
        end else begin
            bus_rd <= 1'b0;
            bus_wr <= 1'b0;
            case (next_state)
                ST_VHI: begin
                    bus_rd   <= 1'b1;
                    bus_addr <= vec_q;
                end
                ST_VLO: begin
                    bus_rd   <= 1'b1;
                    bus_addr <= cas_pkg::add16(vec_q, 16'h0001);
                end
                ST_PREF: begin
                    bus_rd   <= 1'b1;
                    bus_addr <= (state == ST_PREF) ?
                                cas_pkg::add16(pc, {13'h0000, cnt + 3'h1}) : pc;
                end
                ST_OPF: begin
                    bus_rd   <= 1'b1;
                    bus_addr <= cas_pkg::add16(pc, 16'h0001);
                end
                ST_RELF: begin
                    bus_rd   <= 1'b1;
                    bus_addr <= pc;
                end
                ST_PUSH: begin
                    bus_wr    <= 1'b1;
                    bus_addr  <= sp;
                    bus_wdata <= push_byte;
                end
                default: begin
                    bus_addr <= bus_addr;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc     <= 16'h0000;
            opnd   <= 16'h0000;
            opbase <= 16'h0000;
        end else begin
            case (state)
                ST_VHI:  pc[15:8] <= bus_rdata;
                ST_VLO:  pc[7:0] <= bus_rdata;
                ST_IDLE: if (take_op) begin
                    pc     <= cas_pkg::add16(pc, 16'h0001);
                    opbase <= cas_pkg::add16(pc, 16'h0001);
                    opnd   <= 16'h0000;
                end
                ST_OPF: begin
                    opnd <= {opnd[7:0], bus_rdata};
                    pc   <= cas_pkg::add16(pc, 16'h0001);
                end
                ST_RELF: pc <= cas_pkg::add16(pc, 16'h0001);
                ST_BR:   if (br_decide && br_taken) begin
                    pc <= cas_pkg::add16(pc, cas_pkg::sext8(rel_off));
                end
                default: pc <= pc;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hx <= 16'h0000;
            sp <= cas_pkg::SP_RESET;
        end else begin
            if (state == ST_EA && postinc) hx <= cas_pkg::add16(hx, 16'h0001);
            else if (state == ST_IDLE && hx_load) hx <= hx_in;
            if (next_state == ST_PUSH) sp <= cas_pkg::add16(sp, 16'hffff);
            else if (state == ST_IDLE && sp_load) sp <= sp_in;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            i_mask     <= 1'b1;
            cpu_clk_en <= 1'b1;
            bdm_active <= 1'b0;
        end else begin
            if (state == ST_PUSH && cnt == cas_pkg::PUSH_LAST) i_mask <= 1'b1;
            else if (take_wait) i_mask <= 1'b0;
            else if (state == ST_IDLE && imask_load) i_mask <= imask_in;
            if (take_wait) cpu_clk_en <= 1'b0;
            else if (wake_irq || wake_bdm) cpu_clk_en <= 1'b1;
            if (wake_bdm) bdm_active <= 1'b1;
            else if (state == ST_BDM && bdm_go) bdm_active <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ea_addr     <= 16'h0000;
            ea_valid    <= 1'b0;
            op_data     <= 16'h0000;
            seq_idle    <= 1'b0;
            branch_wait <= 1'b0;
        end else begin
            ea_valid    <= (state == ST_EA);
            seq_idle    <= (next_state == ST_IDLE);
            branch_wait <= (next_state == ST_BR);
            if (state == ST_EA) begin
                ea_addr <= eif.ea;
                op_data <= opnd;
            end
        end
    end

    a_reset_six: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_RST && reset_done) |=> (state != ST_IDLE)[*6] ##1 (state == ST_IDLE))
        else $error("reset sequence not six cycles");
    a_reset_vector: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_RST && reset_done) |=> (bus_rd && bus_addr == 16'hfffe)
        ##1 (bus_rd && bus_addr == 16'hffff))
        else $error("reset vector not read from top two addresses");
    a_push_order: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        push_go |=> (bus_wr && bus_wdata == pc[7:0]) ##1 (bus_wr && bus_wdata == pc[15:8])
        ##1 (bus_wr && bus_wdata == hx[7:0]) ##1 (bus_wr && bus_wdata == acc_in))
        else $error("stacking order wrong");
    a_five_pushes: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        push_go |=> (bus_wr)[*5] ##1 (!bus_wr && sp == $past(sp, 6) - 16'h0005))
        else $error("stack frame not five bytes");
    a_vector_fetch: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_PUSH && cnt == cas_pkg::PUSH_LAST) |=> (i_mask && bus_rd && bus_addr == vec_q)
        ##1 bus_rd ##1 !bus_rd ##1 (bus_rd)[*3] ##1 !bus_rd)
        else $error("vector and prefetch order wrong");
    a_mask_blocks: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_IDLE && i_mask && irq_pending && !swi_req) |=> (state != ST_PUSH))
        else $error("masked interrupt taken");
    a_trap_unmasked: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_IDLE && swi_req) |=> (state == ST_PUSH))
        else $error("software trap not taken");
    a_wait_entry: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        take_wait |=> (!i_mask && !cpu_clk_en && state == ST_WAIT))
        else $error("wait entry wrong");
    a_bdm_wake: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        wake_bdm |=> (bdm_active && cpu_clk_en))
        else $error("background wake failed");
    a_postinc_step: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (state == ST_EA && postinc) |=> (hx == $past(hx) + 16'h0001 &&
        ea_addr == cas_pkg::add16($past(hx), (mode_q == cas_pkg::pointer_postinc_mode) ?
                                  16'h0000 : {8'h00, op_data[7:0]})))
        else $error("pointer post-increment wrong");
    a_inherent_idle: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (take_op && need_now == 2'h0) |=> !bus_rd ##1 (ea_valid && (rel_q || !bus_rd)))
        else $error("operand bus access in no-operand mode");
    a_direct_page: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (ea_valid && mode_q == cas_pkg::direct_mode) |-> (ea_addr[15:8] == 8'h00))
        else $error("direct address outside first page");

endmodule : cas_sequencer
`default_nettype wire

/* inc/cas_pkg.sv */
// Constants, mode codes and address arithmetic for the address sequencer.
// Assumes a 16-bit address bus and an 8-bit data bus on one clock.
package cas_pkg;

    localparam int          ADDR_W           = 16;
    localparam logic [15:0] VEC_RESET        = 16'hfffe;
    localparam logic [15:0] SP_RESET         = 16'h00ff;
    localparam logic [7:0]  DIRECT_PAGE_HI   = 8'h00;
    localparam int          IMASK_BIT        = 3;
    localparam logic [2:0]  PUSH_LAST        = 3'h4;
    localparam logic [2:0]  PREF_LAST        = 3'h2;
    localparam int          RESET_SEQ_CYCLES = 6;

    typedef enum logic [3:0] {
        register_only_mode,
        relative_mode,
        literal_operand_mode,
        direct_mode,
        full_address_mode,
        pointer_no_offset_mode,
        pointer_postinc_mode,
        pointer_byte_offset_mode,
        pointer_byte_offset_postinc_mode,
        pointer_word_offset_mode,
        stack_byte_offset_mode,
        stack_word_offset_mode
    } cas_mode_t;

    // Sums wrap inside the 64 KB space
    function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
        add16 = a + b;
    endfunction : add16

    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction : sext8

    function automatic logic [1:0] operand_bytes(input cas_mode_t m, input logic wide);
        case (m)
            register_only_mode, pointer_no_offset_mode, pointer_postinc_mode: operand_bytes = 2'h0;
            literal_operand_mode: operand_bytes = wide ? 2'h2 : 2'h1;
            full_address_mode, pointer_word_offset_mode, stack_word_offset_mode: operand_bytes = 2'h2;
            default: operand_bytes = 2'h1;
        endcase
    endfunction : operand_bytes

endpackage : cas_pkg

/* inc/cas_ea_if.sv */
// Signals between the sequencer and its effective-address adder.
// Both ends run on the same clock; the adder is purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface cas_ea_if;
    cas_pkg::cas_mode_t mode;
    logic [15:0]        hx;
    logic [15:0]        sp;
    logic [15:0]        base;
    logic [15:0]        pc;
    logic [15:0]        opnd;
    logic [15:0]        ea;
    modport calc (input mode, input hx, input sp, input base, input pc, input opnd, output ea);
    modport user (output mode, output hx, output sp, output base, output pc, output opnd,
                  input ea);
endinterface : cas_ea_if
`default_nettype wire

/* verilog/cas_ea_calc.sv */
// Effective-address adder for every operand addressing mode.
// Assumes operand bytes are already collected high byte first in opnd.
`timescale 1ns/100ps
`default_nettype none
module cas_ea_calc (
    cas_ea_if.calc eif
);
    always_comb begin
        case (eif.mode)
            cas_pkg::relative_mode:
                eif.ea = cas_pkg::add16(eif.pc, cas_pkg::sext8(eif.opnd[7:0]));
            cas_pkg::literal_operand_mode:
                eif.ea = eif.base;
            cas_pkg::direct_mode:
                eif.ea = {cas_pkg::DIRECT_PAGE_HI, eif.opnd[7:0]};
            cas_pkg::full_address_mode:
                eif.ea = eif.opnd;
            cas_pkg::pointer_no_offset_mode, cas_pkg::pointer_postinc_mode:
                eif.ea = eif.hx;
            cas_pkg::pointer_byte_offset_mode, cas_pkg::pointer_byte_offset_postinc_mode:
                eif.ea = cas_pkg::add16(eif.hx, {8'h00, eif.opnd[7:0]});
            cas_pkg::pointer_word_offset_mode:
                eif.ea = cas_pkg::add16(eif.hx, eif.opnd);
            cas_pkg::stack_byte_offset_mode:
                eif.ea = cas_pkg::add16(eif.sp, {8'h00, eif.opnd[7:0]});
            cas_pkg::stack_word_offset_mode:
                eif.ea = cas_pkg::add16(eif.sp, eif.opnd);
            default:
                eif.ea = eif.base; // No operand address in register-only mode
        endcase
    end
endmodule : cas_ea_calc
`default_nettype wire

/* tb/cas_mem_model.sv */
// Flat byte memory standing in for everything on the CPU bus.
// Assumes reads are combinational and writes land at the clock edge.
`timescale 1ns/100ps
`default_nettype none
module cas_mem_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata
);
    logic [7:0] m [0:65535]; // One space for memory, registers and ports
    logic [7:0] last = 8'h00;
    initial for (int i = 0; i < 65536; i++) m[i] = 8'hee;
    // Idle bus shows the inverse of the last byte so stale data cannot pass
    assign bus_rdata = bus_rd ? m[bus_addr] : ~last;
    always @(posedge sys_clk) begin
        if (bus_rd) last <= m[bus_addr];
        if (bus_wr) m[bus_addr] <= bus_wdata;
    end
endmodule : cas_mem_model
`default_nettype wire

/* tb/test_cas_sequencer.sv */
// Self-checking bench for the address and exception sequencer.
// Assumes the memory model answers every bus read in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 300) begin @(negedge sys_clk); k++; end \
    if (!(c)) begin n_fail++; test_done(); end end
module test_cas_sequencer;
    logic sys_clk = 0, arst_n = 0, reset_done = 0, op_start = 0, op_wide = 0, op_rel_tail = 0;
    logic br_decide = 0, br_taken = 0, irq_pending = 0, swi_req = 0, wait_req = 0;
    logic bdm_background = 0, bdm_go = 0, hx_load = 0, sp_load = 0, imask_load = 0, imask_in = 0;
    cas_pkg::cas_mode_t op_mode = cas_pkg::register_only_mode;
    logic [15:0] int_vector = 16'hfff8, hx_in = 16'h0000, sp_in = 16'h0000, p;
    logic [7:0]  acc_in = 8'h11, ccr_in = 8'h60, bus_rdata, bus_wdata;
    logic [15:0] bus_addr, ea_addr, op_data, pc, hx, sp;
    logic        bus_rd, bus_wr, ea_valid, i_mask, cpu_clk_en, bdm_active, seq_idle, branch_wait;
    int          n_fail = 0, checked = 0, k, rd;
    cas_sequencer dut (.*);
    cas_mem_model mem (.*);
    always #12.5 sys_clk = ~sys_clk;
    task test_done;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task rst;
        arst_n = 0;
        reset_done = 0;
        #1 `CHK(bus_wr, 1'b0)
        `CHK(pc, 16'h0000)
        repeat (2) @(negedge sys_clk);
        arst_n = 1;
        @(negedge sys_clk) reset_done = 1;
        `WAITC(seq_idle)
        `CHK(k, 7)
        `CHK(pc, 16'h2000)
        `CHK(sp, 16'h00ff)
    endtask : rst
    task ld(input logic [15:0] h, input logic [15:0] s, input logic im);
        @(negedge sys_clk);
        `WAITC(seq_idle)
        {hx_load, hx_in, sp_load, sp_in, imask_load, imask_in} = {1'b1, h, 1'b1, s, 1'b1, im};
        @(negedge sys_clk) {hx_load, sp_load, imask_load} = 3'h0;
    endtask : ld
    task op(input cas_pkg::cas_mode_t m, input logic w, input logic t, input logic [15:0] e_ea,
            input logic [15:0] e_d, input int n, input logic [15:0] e_hx);
        @(negedge sys_clk);
        `WAITC(seq_idle)
        op_start = 1'b1;
        op_mode = m;
        {op_wide, op_rel_tail} = {w, t};
        @(negedge sys_clk) op_start = 0;
        rd = 0;
        k = 0;
        while (!ea_valid && k < 20) begin
            rd += bus_rd;
            @(negedge sys_clk) k++;
        end
        `CHK(k, n + 1)
        if (!ea_valid) test_done();
        if (m != cas_pkg::register_only_mode) `CHK(ea_addr, e_ea)
        if (n > 0) `CHK(op_data, e_d)
        `CHK(rd, n)
        `CHK(hx, e_hx)
    endtask : op
    task br;
        `WAITC(branch_wait)
        p = pc;
        {br_decide, br_taken} = 2'h3;
        @(negedge sys_clk) br_decide = 0;
        `CHK(pc, p + 16'hffc4)
    endtask : br
    task trap(input logic software_trap, input logic [15:0] e_sp, input logic [7:0] e_ccr);
        @(negedge sys_clk);
        `WAITC(seq_idle)
        p = pc;
        if (software_trap) swi_req = 1;
        else irq_pending = 1;
        @(negedge sys_clk) swi_req = 0;
        `WAITC(seq_idle)
        irq_pending = 0;
        `CHK(k, 11)
        `CHK({mem.m[e_sp+5], mem.m[e_sp+4]}, {p[7:0], p[15:8]})
        `CHK({mem.m[e_sp+3], mem.m[e_sp+2], mem.m[e_sp+1]}, {8'ha5, 8'h11, e_ccr})
        `CHK(mem.m[e_sp], 8'hee)
        `CHK({sp, pc, i_mask}, {e_sp, 16'h3000, 1'b1})
    endtask : trap
    task t_modes;
        ld(16'hfffe, 16'h0150, 1'b1);
        op(cas_pkg::register_only_mode, 0, 0, 0, 0, 0, 16'hfffe);
        op(cas_pkg::literal_operand_mode, 0, 0, 16'h2002, 16'h00c4, 1, 16'hfffe);
        op(cas_pkg::literal_operand_mode, 1, 0, 16'h2004, 16'hc4c4, 2, 16'hfffe);
        op(cas_pkg::direct_mode, 0, 0, 16'h00c4, 16'h00c4, 1, 16'hfffe);
        op(cas_pkg::full_address_mode, 0, 0, 16'hc4c4, 16'hc4c4, 2, 16'hfffe);
        op(cas_pkg::pointer_no_offset_mode, 0, 0, 16'hfffe, 0, 0, 16'hfffe);
        op(cas_pkg::pointer_postinc_mode, 0, 0, 16'hfffe, 0, 0, 16'hffff);
        op(cas_pkg::pointer_byte_offset_mode, 0, 0, 16'h00c3, 16'h00c4, 1, 16'hffff);
        op(cas_pkg::pointer_byte_offset_postinc_mode, 0, 0, 16'h00c3, 16'h00c4, 1, 0);
        op(cas_pkg::pointer_word_offset_mode, 0, 0, 16'hc4c4, 16'hc4c4, 2, 0);
        op(cas_pkg::stack_byte_offset_mode, 0, 0, 16'h0214, 16'h00c4, 1, 0);
        op(cas_pkg::stack_word_offset_mode, 0, 0, 16'hc614, 16'hc4c4, 2, 0);
        op(cas_pkg::relative_mode, 0, 0, 16'h1fdf, 16'h00c4, 1, 0);
        `CHK(branch_wait, 1'b1)
        br();
        op(cas_pkg::direct_mode, 0, 1, 16'h00c4, 16'h00c4, 1, 0);
        br();
    endtask : t_modes
    task t_traps;
        ld(16'h5aa5, 16'h0180, 1'b0);
        trap(0, 16'h017b, 8'h60);
        // Masked request must not steal the operand sequence
        irq_pending = 1;
        op(cas_pkg::direct_mode, 0, 0, 16'h00c4, 16'h00c4, 1, 16'h5aa5);
        trap(1, 16'h0176, 8'h68);
    endtask : t_traps
    task t_wait;
        @(negedge sys_clk) wait_req = 1;
        @(negedge sys_clk) wait_req = 0;
        `CHK({i_mask, cpu_clk_en}, 2'h0)
        bdm_background = 1;
        @(negedge sys_clk) bdm_background = 0;
        `CHK({bdm_active, cpu_clk_en}, 2'h3)
        bdm_go = 1;
        @(negedge sys_clk) bdm_go = 0;
        `WAITC(seq_idle)
        `CHK(bdm_active, 1'b0)
        wait_req = 1;
        @(negedge sys_clk) {wait_req, irq_pending} = 2'h1;
        `WAITC(seq_idle && sp == 16'h0171)
        irq_pending = 0;
        `CHK({cpu_clk_en, i_mask, pc}, {2'h3, 16'h3000})
        // Reset lands in the middle of a stacking run
        swi_req = 1;
        @(negedge sys_clk) swi_req = 0;
        @(negedge sys_clk);
        rst();
    endtask : t_wait
    initial begin
        #1 for (int a = 'h1000; a < 'h4000; a++) mem.m[a] = 8'hc4;
        {mem.m[16'hfffe], mem.m[16'hffff], mem.m[16'hfff8], mem.m[16'hfff9]} = 32'h2000_3000;
        rst();
        t_modes();
        t_traps();
        t_wait();
        test_done();
    end
endmodule : test_cas_sequencer
`default_nettype wire
